/* File: core/clock_power_pkg.sv */
// Shared constants for the key-protected clock and power controller
package clock_power_pkg;

  // ----------------------------------------------------------------
  // Register byte addresses
  // ----------------------------------------------------------------
  localparam logic [31:0] ADDR_POWER_UNLOCK_FIRST = 32'hffff0404;
  localparam logic [31:0] ADDR_POWER_CONTROL = 32'hffff0408;
  localparam logic [31:0] ADDR_POWER_UNLOCK_SECOND = 32'hffff040c;
  localparam logic [31:0] ADDR_PLL_UNLOCK_FIRST = 32'hffff0410;
  localparam logic [31:0] ADDR_PLL_CONTROL = 32'hffff0414;
  localparam logic [31:0] ADDR_PLL_UNLOCK_SECOND = 32'hffff0418;
  localparam logic [31:0] ADDR_CLOCK_STATUS = 32'hffff041c;

  // ----------------------------------------------------------------
  // Decoded register index
  // ----------------------------------------------------------------
  typedef enum logic [2:0] {
    IDX_NONE = 3'b000,
    IDX_POW_KEY1 = 3'b001,
    IDX_POW_CTL = 3'b010,
    IDX_POW_KEY2 = 3'b011,
    IDX_PLL_KEY1 = 3'b100,
    IDX_PLL_CTL = 3'b101,
    IDX_PLL_KEY2 = 3'b110,
    IDX_STATUS = 3'b111
  } reg_index_t;

  // ----------------------------------------------------------------
  // Keys and reset values
  // ----------------------------------------------------------------
  localparam logic [7:0] PLL_KEY_FIRST = 8'haa;
  localparam logic [7:0] PLL_KEY_SECOND = 8'h55;
  localparam logic [7:0] POW_KEY_FIRST = 8'h01;
  localparam logic [7:0] POW_KEY_SECOND = 8'hf4;
  localparam logic [7:0] PLL_CONTROL_RESET = 8'h21;
  localparam logic [7:0] POWER_CONTROL_RESET = 8'h03;

  // ----------------------------------------------------------------
  // Field positions
  // ----------------------------------------------------------------
  localparam int REF_SEL_BIT = 5;
  localparam int SRC_HI = 1;
  localparam int SRC_LO = 0;
  localparam int MODE_HI = 6;
  localparam int MODE_LO = 4;
  localparam int DIV_HI = 2;
  localparam int DIV_LO = 0;

  // ----------------------------------------------------------------
  // Field encodings
  // ----------------------------------------------------------------
  localparam logic [1:0] SRC_PLL = 2'h1;
  localparam logic [1:0] SRC_EXT_PIN = 2'h3;
  localparam logic REF_INTERNAL_OSC = 1'b1;

  typedef enum logic [2:0] {
    MODE_ACTIVE = 3'b000,
    MODE_PAUSE = 3'b001,
    MODE_NAP = 3'b010,
    MODE_SLEEP = 3'b011,
    MODE_STOP = 3'b100
  } op_mode_t;

  // PLL multiplies the 32.768 kHz reference by this factor
  localparam logic [10:0] PLL_MULTIPLIER = 11'h4fb;
  localparam int NUM_EXT_IRQ = 4;

endpackage : clock_power_pkg

/* File: core/core_clock_if.sv */
// Link between the controller and its core clock divider
`timescale 1ns/1ps
`default_nettype none

interface core_clock_if;
  logic [2:0] divide;
  logic run;
  logic tick;

  modport ctrl (output divide, output run, input tick);
  modport div (input divide, input run, output tick);
endinterface : core_clock_if

`default_nettype wire

/* File: core/core_clock_divider.sv */
// Binary core clock divider producing a one-cycle core tick
`timescale 1ns/1ps
`default_nettype none

module core_clock_divider (
  input wire logic i_clock,
  input wire logic i_reset_n,
  core_clock_if.div b
);

  typedef struct packed {
    logic [6:0] cnt;
    logic tick;
  } div_state_t;

  div_state_t s_q;
  div_state_t s_d;

  // ----------------------------------------------------------------
  // Divide by two to the power of cd
  // ----------------------------------------------------------------
  always_comb begin
    logic [7:0] full;
    logic [6:0] mask;
    full = 8'h01 << b.divide;
    mask = 7'(full - 8'h01);
    s_d = s_q;
    if (b.run) begin
      s_d.cnt = s_q.cnt + 7'h01;
      s_d.tick = ((s_q.cnt & mask) == mask);
    end else begin
      s_d.cnt = 7'h00;
      s_d.tick = 1'b0;
    end
  end

  always_ff @(posedge i_clock) begin
    if (!i_reset_n) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end

  assign b.tick = s_q.tick;

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  AST_DIV_SPACING: assert property (@(posedge i_clock)
    disable iff (!i_reset_n)
    (b.tick && b.run && b.divide != 3'h0 && $stable(b.divide)) |=> !b.tick)
    else $error("core tick repeated while dividing");

  AST_DIV_FULL: assert property (@(posedge i_clock)
    disable iff (!i_reset_n)
    (b.run && b.divide == 3'h0) [*3] |-> b.tick)
    else $error("undivided core tick missing");

endmodule : core_clock_divider

`default_nettype wire

/* File: core/key_protected_power_clock_control.sv */
// Key-protected clock source and power mode controller, AHB-Lite slave
//
// Implementation choice: the AHB-Lite slave port.
`timescale 1ns/1ps
`default_nettype none

module key_protected_power_clock_control (
  input wire logic I_CLOCK,
  input wire logic I_RESET_N,
  input wire logic I_HSEL,
  input wire logic [31:0] I_HADDR,
  input wire logic [1:0] I_HTRANS,
  input wire logic I_HWRITE,
  input wire logic [2:0] I_HSIZE,
  input wire logic [31:0] I_HWDATA,
  input wire logic I_HREADY,
  output logic O_HREADYOUT,
  output logic O_HRESP,
  output logic [31:0] O_HRDATA,
  input wire logic I_PLL_LOCK,
  input wire logic [3:0] I_EXTERNAL_IRQ,
  input wire logic I_GENERAL_TIMER_TWO,
  output logic O_PLL_REFERENCE_SELECT,
  output logic [1:0] O_CLOCK_SOURCE_MODE,
  output logic [2:0] O_OPERATING_MODE,
  output logic [2:0] O_CORE_CLOCK_DIVIDE,
  output logic [10:0] O_PLL_MULTIPLIER,
  output logic O_CORE_CLOCK_ENABLE,
  output logic O_CORE_RUN,
  output logic O_PERIPH_RUN,
  output logic O_PLL_ENABLE,
  output logic O_XTAL_TIMER_ENABLE,
  output logic O_PLL_IRQ
);

  typedef enum logic [2:0] {
    S_IDLE = 3'b000,
    S_PLL_KEYED = 3'b001,
    S_PLL_VALUE = 3'b010,
    S_POW_KEYED = 3'b011,
    S_POW_VALUE = 3'b100
  } seq_state_t;

  typedef struct packed {
    seq_state_t seq;
    logic [7:0] pend;
    logic [7:0] pll;
    logic [7:0] pow;
    logic [1:0] src;
    logic ref_sel;
    logic wr;
    clock_power_pkg::reg_index_t widx;
    logic [31:0] rdata;
    logic lock_s1;
    logic lock_s2;
    logic lock_prev;
    logic [3:0] irq_s1;
    logic [3:0] irq_s2;
    logic tmr_s1;
    logic tmr_s2;
    logic pll_irq;
  } ctl_state_t;

  ctl_state_t s_q;
  ctl_state_t s_d;
  core_clock_if clk_link ();

  // ----------------------------------------------------------------
  // Address decode and mode helpers
  // ----------------------------------------------------------------
  function automatic clock_power_pkg::reg_index_t decode(
    input logic [31:0] a
  );
    case (a)
      clock_power_pkg::ADDR_POWER_UNLOCK_FIRST:
        decode = clock_power_pkg::IDX_POW_KEY1;
      clock_power_pkg::ADDR_POWER_CONTROL:
        decode = clock_power_pkg::IDX_POW_CTL;
      clock_power_pkg::ADDR_POWER_UNLOCK_SECOND:
        decode = clock_power_pkg::IDX_POW_KEY2;
      clock_power_pkg::ADDR_PLL_UNLOCK_FIRST:
        decode = clock_power_pkg::IDX_PLL_KEY1;
      clock_power_pkg::ADDR_PLL_CONTROL:
        decode = clock_power_pkg::IDX_PLL_CTL;
      clock_power_pkg::ADDR_PLL_UNLOCK_SECOND:
        decode = clock_power_pkg::IDX_PLL_KEY2;
      clock_power_pkg::ADDR_CLOCK_STATUS:
        decode = clock_power_pkg::IDX_STATUS;
      default: decode = clock_power_pkg::IDX_NONE;
    endcase
  endfunction : decode

  // Reserved mode codes run as active
  function automatic logic [2:0] mode_of(input logic [7:0] p);
    logic [2:0] m;
    m = p[clock_power_pkg::MODE_HI:clock_power_pkg::MODE_LO];
    if (m > clock_power_pkg::MODE_STOP) begin
      mode_of = clock_power_pkg::MODE_ACTIVE;
    end else begin
      mode_of = m;
    end
  endfunction : mode_of

  // ----------------------------------------------------------------
  // Next state
  // ----------------------------------------------------------------
  always_comb begin
    logic [7:0] wd;
    logic [2:0] mode;
    logic ext_wake;
    logic src_ok;
    wd = I_HWDATA[7:0];
    s_d = s_q;
    mode = mode_of(s_q.pow);
    ext_wake = |s_q.irq_s2;
    src_ok = (s_q.pll[clock_power_pkg::SRC_HI:clock_power_pkg::SRC_LO]
              == clock_power_pkg::SRC_PLL) ||
             (s_q.pll[clock_power_pkg::SRC_HI:clock_power_pkg::SRC_LO]
              == clock_power_pkg::SRC_EXT_PIN);
    // Two-stage synchronisers
    s_d.lock_s1 = I_PLL_LOCK;
    s_d.lock_s2 = s_q.lock_s1;
    s_d.irq_s1 = I_EXTERNAL_IRQ;
    s_d.irq_s2 = s_q.irq_s1;
    s_d.tmr_s1 = I_GENERAL_TIMER_TWO;
    s_d.tmr_s2 = s_q.tmr_s1;
    s_d.lock_prev = s_q.lock_s2;
    s_d.pll_irq = s_q.lock_s2 && !s_q.lock_prev;
    // Wake from low-power modes
    case (mode)
      clock_power_pkg::MODE_PAUSE, clock_power_pkg::MODE_NAP,
      clock_power_pkg::MODE_SLEEP: begin
        if (ext_wake || s_q.tmr_s2) begin
          s_d.pow[clock_power_pkg::MODE_HI:clock_power_pkg::MODE_LO] =
            clock_power_pkg::MODE_ACTIVE;
        end
      end
      clock_power_pkg::MODE_STOP: begin
        if (ext_wake) begin
          s_d.pow[clock_power_pkg::MODE_HI:clock_power_pkg::MODE_LO] =
            clock_power_pkg::MODE_ACTIVE;
        end
      end
      default: begin
      end
    endcase
    // Source change only on timer wake from nap
    if (mode == clock_power_pkg::MODE_NAP && s_q.tmr_s2) begin
      s_d.ref_sel = s_q.pll[clock_power_pkg::REF_SEL_BIT];
      if (src_ok) begin
        s_d.src = s_q.pll[clock_power_pkg::SRC_HI:clock_power_pkg::SRC_LO];
      end
    end
    // Key sequence tracker on write data phase
    if (s_q.wr) begin
      s_d.seq = S_IDLE;
      case (s_q.widx)
        clock_power_pkg::IDX_PLL_KEY1: begin
          if (wd == clock_power_pkg::PLL_KEY_FIRST) begin
            s_d.seq = S_PLL_KEYED;
          end
        end
        clock_power_pkg::IDX_PLL_CTL: begin
          if (s_q.seq == S_PLL_KEYED) begin
            s_d.pend = wd;
            s_d.seq = S_PLL_VALUE;
          end
        end
        clock_power_pkg::IDX_PLL_KEY2: begin
          if (s_q.seq == S_PLL_VALUE &&
              wd == clock_power_pkg::PLL_KEY_SECOND) begin
            s_d.pll = s_q.pend;
          end
        end
        clock_power_pkg::IDX_POW_KEY1: begin
          if (wd == clock_power_pkg::POW_KEY_FIRST) begin
            s_d.seq = S_POW_KEYED;
          end
        end
        clock_power_pkg::IDX_POW_CTL: begin
          if (s_q.seq == S_POW_KEYED) begin
            s_d.pend = wd;
            s_d.seq = S_POW_VALUE;
          end
        end
        clock_power_pkg::IDX_POW_KEY2: begin
          if (s_q.seq == S_POW_VALUE &&
              wd == clock_power_pkg::POW_KEY_SECOND) begin
            s_d.pow = s_q.pend;
          end
        end
        default: begin
        end
      endcase
    end
    // Address phase capture; read data from next-state values
    s_d.wr = I_HSEL && I_HTRANS[1] && I_HWRITE && I_HREADY;
    s_d.widx = decode(I_HADDR);
    s_d.rdata = 32'h0000_0000;
    if (I_HSEL && I_HTRANS[1] && !I_HWRITE && I_HREADY) begin
      case (decode(I_HADDR))
        clock_power_pkg::IDX_PLL_CTL: s_d.rdata = {24'h000000, s_d.pll};
        clock_power_pkg::IDX_POW_CTL: s_d.rdata = {24'h000000, s_d.pow};
        clock_power_pkg::IDX_STATUS:
          s_d.rdata = {24'h000000, 1'b0, s_d.seq, s_d.lock_s2,
                       s_d.ref_sel, s_d.src};
        default: s_d.rdata = 32'h0000_0000;
      endcase
    end
  end

  always_ff @(posedge I_CLOCK) begin
    if (!I_RESET_N) begin
      s_q <= '{seq: S_IDLE, pend: 8'h00,
               pll: clock_power_pkg::PLL_CONTROL_RESET,
               pow: clock_power_pkg::POWER_CONTROL_RESET,
               src: clock_power_pkg::SRC_PLL,
               ref_sel: clock_power_pkg::REF_INTERNAL_OSC,
               wr: 1'b0, widx: clock_power_pkg::IDX_NONE,
               rdata: 32'h0000_0000, irq_s1: 4'h0, irq_s2: 4'h0,
               default: 1'b0};
    end else begin
      s_q <= s_d;
    end
  end

  // ----------------------------------------------------------------
  // Core clock divider and power outputs
  // ----------------------------------------------------------------
  assign clk_link.divide =
    s_q.pow[clock_power_pkg::DIV_HI:clock_power_pkg::DIV_LO];
  assign clk_link.run = O_CORE_RUN && s_q.lock_s2;

  core_clock_divider u_divider (
    .i_clock(I_CLOCK),
    .i_reset_n(I_RESET_N),
    .b(clk_link.div)
  );

  assign O_HREADYOUT = 1'b1;
  assign O_HRESP = 1'b0;
  assign O_HRDATA = s_q.rdata;
  assign O_PLL_REFERENCE_SELECT = s_q.ref_sel;
  assign O_CLOCK_SOURCE_MODE = s_q.src;
  assign O_OPERATING_MODE = mode_of(s_q.pow);
  assign O_CORE_CLOCK_DIVIDE = clk_link.divide;
  assign O_PLL_MULTIPLIER = clock_power_pkg::PLL_MULTIPLIER;
  assign O_CORE_CLOCK_ENABLE = clk_link.tick && s_q.lock_s2;
  assign O_CORE_RUN =
    (O_OPERATING_MODE == clock_power_pkg::MODE_ACTIVE);
  assign O_PERIPH_RUN =
    (O_OPERATING_MODE <= clock_power_pkg::MODE_PAUSE);
  assign O_PLL_ENABLE = (O_OPERATING_MODE <= clock_power_pkg::MODE_NAP);
  assign O_XTAL_TIMER_ENABLE =
    (O_OPERATING_MODE <= clock_power_pkg::MODE_SLEEP);
  assign O_PLL_IRQ = s_q.pll_irq;

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge I_CLOCK); endclocking
  default disable iff (!I_RESET_N);

  sequence pll_keyed_s;
    s_q.seq == S_PLL_VALUE && s_q.wr &&
    s_q.widx == clock_power_pkg::IDX_PLL_KEY2;
  endsequence

  AST_PLL_COMMIT: assert property ($changed(s_q.pll) |->
    $past(s_q.seq) == S_PLL_VALUE)
    else $error("pll control changed without unlock");

  AST_PLL_TAKE: assert property ((pll_keyed_s
    and (I_HWDATA[7:0] == clock_power_pkg::PLL_KEY_SECOND))
    |=> s_q.pll == $past(s_q.pend))
    else $error("pll control value not taken");

  AST_POW_COMMIT: assert property ($changed(O_CORE_CLOCK_DIVIDE)
    |-> $past(s_q.seq) == S_POW_VALUE)
    else $error("divider changed without unlock");

  AST_REF_RESET: assert property ($rose(I_RESET_N) |->
    O_PLL_REFERENCE_SELECT)
    else $error("reference select not internal after reset");

  AST_SRC_LEGAL: assert property (O_CLOCK_SOURCE_MODE == 2'h1 ||
    O_CLOCK_SOURCE_MODE == 2'h3)
    else $error("reserved clock source applied");

  AST_MODE_LEGAL: assert property (O_OPERATING_MODE <= 3'h4)
    else $error("reserved operating mode shown");

  AST_SLEEP_WAKE: assert property ((O_OPERATING_MODE == 3'h3 &&
    (|s_q.irq_s2) && !(s_q.wr && s_q.widx == clock_power_pkg::IDX_POW_KEY2))
    |=> O_OPERATING_MODE == 3'h0)
    else $error("sleep not ended by interrupt");

  AST_STOP_OFF: assert property (O_OPERATING_MODE == 3'h4 |->
    !O_CORE_RUN && !O_PERIPH_RUN && !O_PLL_ENABLE && !O_XTAL_TIMER_ENABLE)
    else $error("stop mode left logic powered");

  AST_LOCK_HALT: assert property (!s_q.lock_s2 |-> !O_CORE_CLOCK_ENABLE
    && !O_PLL_IRQ)
    else $error("core clock ran without lock");

  AST_SRC_NAP: assert property ($changed(O_CLOCK_SOURCE_MODE) |->
    $past(O_OPERATING_MODE) == 3'h2 && $past(s_q.tmr_s2))
    else $error("clock source changed outside nap wake");

  AST_SEQ_ABORT: assert property ((s_q.wr &&
    s_q.widx == clock_power_pkg::IDX_NONE) |=> s_q.seq == S_IDLE)
    else $error("stray write left sequence armed");

endmodule : key_protected_power_clock_control

`default_nettype wire

/* File: test/tb_key_protected_power_clock_control.sv */
// Self-checking testbench for the key-protected clock and power controller
`timescale 1ns/1ps
`default_nettype none

module tb_key_protected_power_clock_control;
  logic clk;
  logic rst_n;
  logic hsel;
  logic [31:0] haddr;
  logic [1:0] htrans;
  logic hwrite;
  logic [31:0] hwdata;
  logic lock;
  logic [3:0] irq;
  logic tmr;
  wire logic hready;
  wire logic hresp;
  wire logic [31:0] hrdata;
  wire logic ref_sel;
  wire logic [1:0] src;
  wire logic [2:0] mode;
  wire logic [2:0] div;
  wire logic [10:0] mult;
  wire logic cen;
  wire logic core_run;
  wire logic per_run;
  wire logic pll_en;
  wire logic xtal_en;
  wire logic pll_irq;
  int err_count;
  int n_tests;

  key_protected_power_clock_control uut (
    .I_CLOCK(clk), .I_RESET_N(rst_n), .I_HSEL(hsel), .I_HADDR(haddr),
    .I_HTRANS(htrans), .I_HWRITE(hwrite), .I_HSIZE(3'b010),
    .I_HWDATA(hwdata), .I_HREADY(hready), .O_HREADYOUT(hready),
    .O_HRESP(hresp), .O_HRDATA(hrdata), .I_PLL_LOCK(lock),
    .I_EXTERNAL_IRQ(irq), .I_GENERAL_TIMER_TWO(tmr),
    .O_PLL_REFERENCE_SELECT(ref_sel), .O_CLOCK_SOURCE_MODE(src),
    .O_OPERATING_MODE(mode), .O_CORE_CLOCK_DIVIDE(div),
    .O_PLL_MULTIPLIER(mult), .O_CORE_CLOCK_ENABLE(cen),
    .O_CORE_RUN(core_run), .O_PERIPH_RUN(per_run), .O_PLL_ENABLE(pll_en),
    .O_XTAL_TIMER_ENABLE(xtal_en), .O_PLL_IRQ(pll_irq)
  );

  initial begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end

  // ----------------------------------------------------------------
  // Shared tasks
  // ----------------------------------------------------------------
  task automatic test_done();
    $display("Comparisons %0d, mismatches %0d", n_tests, err_count);
    if (err_count == 0 && n_tests > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask : test_done

  task automatic chk(input logic [31:0] got, input logic [31:0] exp,
                     input string what);
    n_tests++;
    if (got !== exp) begin
      err_count++;
      $display("Error at %0t: %s got %h expected %h", $time, what, got, exp);
    end
  endtask : chk

  task automatic wait_ready();
    int k;
    k = 0;
    do begin
      @(posedge clk);
      k++;
    end while (hready !== 1'b1 && k < 20);
    if (hready !== 1'b1) begin
      err_count++;
      $display("Error at %0t: bus wait ran out", $time);
      test_done();
    end
  endtask : wait_ready

  task automatic bus(input logic wr, input logic [31:0] a,
                     input logic [7:0] d, output logic [31:0] rd);
    hsel <= 1'b1;
    haddr <= a;
    hwrite <= wr;
    htrans <= 2'b10;
    wait_ready();
    hsel <= 1'b0;
    htrans <= 2'b00;
    hwdata <= {24'h0, d};
    wait_ready();
    rd = hrdata;
  endtask : bus

  task automatic wr(input logic [31:0] a, input logic [7:0] d);
    logic [31:0] rd;
    bus(1'b1, a, d, rd);
  endtask : wr

  task automatic rdchk(input logic [31:0] a, input logic [31:0] exp);
    logic [31:0] rd;
    bus(1'b0, a, 8'h00, rd);
    chk(rd, exp, "read data");
  endtask : rdchk

  task automatic pow_set(input logic [7:0] v);
    wr(clock_power_pkg::ADDR_POWER_UNLOCK_FIRST, 8'h01);
    wr(clock_power_pkg::ADDR_POWER_CONTROL, v);
    wr(clock_power_pkg::ADDR_POWER_UNLOCK_SECOND, 8'hf4);
    @(posedge clk);
  endtask : pow_set

  task automatic pll_seq(input logic [7:0] k1, input logic [7:0] v,
                         input logic [7:0] k2);
    wr(clock_power_pkg::ADDR_PLL_UNLOCK_FIRST, k1);
    wr(clock_power_pkg::ADDR_PLL_CONTROL, v);
    wr(clock_power_pkg::ADDR_PLL_UNLOCK_SECOND, k2);
  endtask : pll_seq

  task automatic wait_mode(input logic [2:0] exp);
    int k;
    k = 0;
    while (mode !== exp && k < 20) begin
      @(posedge clk);
      k++;
    end
    chk(mode, exp, "wake to mode");
    if (mode !== exp) test_done();
  endtask : wait_mode

  task automatic count(input int n, output logic [31:0] c_en,
                       output logic [31:0] c_irq);
    c_en = 0;
    c_irq = 0;
    repeat (n) begin
      @(posedge clk);
      if (cen === 1'b1) c_en++;
      if (pll_irq === 1'b1) c_irq++;
    end
  endtask : count

  // ----------------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------------
  task automatic t_reset();
    chk(ref_sel, 1'b1, "reference at reset");
    chk(src, 2'b01, "source at reset");
    chk(div, 3'h3, "divide at reset");
    chk(mult, 11'h4fb, "multiplier");
    chk(hresp, 1'b0, "bus response");
    rdchk(clock_power_pkg::ADDR_PLL_CONTROL, 32'h21);
    rdchk(clock_power_pkg::ADDR_POWER_CONTROL, 32'h03);
    rdchk(clock_power_pkg::ADDR_PLL_UNLOCK_FIRST, 32'h0);
    rdchk(clock_power_pkg::ADDR_POWER_UNLOCK_SECOND, 32'h0);
  endtask : t_reset

  task automatic t_keys();
    wr(clock_power_pkg::ADDR_PLL_CONTROL, 8'h03);
    rdchk(clock_power_pkg::ADDR_PLL_CONTROL, 32'h21);
    wr(clock_power_pkg::ADDR_PLL_UNLOCK_FIRST, 8'haa);
    rdchk(clock_power_pkg::ADDR_CLOCK_STATUS, 32'h1d);
    wr(clock_power_pkg::ADDR_PLL_CONTROL, 8'h03);
    wr(32'hffff0400, 8'h00);
    wr(clock_power_pkg::ADDR_PLL_UNLOCK_SECOND, 8'h55);
    rdchk(clock_power_pkg::ADDR_PLL_CONTROL, 32'h21);
    pll_seq(8'haa, 8'h03, 8'h54);
    rdchk(clock_power_pkg::ADDR_PLL_CONTROL, 32'h21);
    wr(clock_power_pkg::ADDR_POWER_UNLOCK_FIRST, 8'h01);
    wr(clock_power_pkg::ADDR_POWER_CONTROL, 8'h20);
    wr(clock_power_pkg::ADDR_POWER_UNLOCK_SECOND, 8'hf5);
    rdchk(clock_power_pkg::ADDR_POWER_CONTROL, 32'h03);
    chk(mode, 3'h0, "mode after bad key");
    rdchk(32'hffff0400, 32'h0);
  endtask : t_keys

  task automatic t_divide();
    logic [31:0] ce;
    logic [31:0] ci;
    for (int d = 0; d < 8; d++) begin
      pow_set(8'(d));
      chk(div, 32'(d), "divide output");
      repeat (4) @(posedge clk);
      count(256, ce, ci);
      chk(ce, 32'(256 >> d), "core enable pulses");
    end
    rdchk(clock_power_pkg::ADDR_POWER_CONTROL, 32'h07);
  endtask : t_divide

  task automatic t_modes();
    logic [3:0] lv [5];
    lv = '{4'hf, 4'h7, 4'h3, 4'h1, 4'h0};
    for (int m = 0; m < 5; m++) begin
      pow_set({1'b0, 3'(m), 4'h3});
      chk(mode, 32'(m), "mode output");
      chk({core_run, per_run, pll_en, xtal_en}, lv[m], "run levels");
      if (m == 4) begin
        tmr <= 1'b1;
        repeat (8) @(posedge clk);
        chk(mode, 3'h4, "stop ignores timer");
        tmr <= 1'b0;
      end
      if (m > 0) begin
        irq[m - 1] <= 1'b1;
        wait_mode(3'h0);
        irq[m - 1] <= 1'b0;
        repeat (4) @(posedge clk);
      end
    end
    pow_set(8'h33);
    tmr <= 1'b1;
    wait_mode(3'h0);
    tmr <= 1'b0;
    pow_set(8'h53);
    rdchk(clock_power_pkg::ADDR_POWER_CONTROL, 32'h53);
    chk(mode, 3'h0, "reserved mode");
  endtask : t_modes

  task automatic t_switch();
    pll_seq(8'haa, 8'h03, 8'h55);
    rdchk(clock_power_pkg::ADDR_PLL_CONTROL, 32'h03);
    chk(src, 2'b01, "source before nap");
    pow_set(8'h23);
    chk(mode, 3'h2, "nap entered");
    tmr <= 1'b1;
    wait_mode(3'h0);
    chk(src, 2'b11, "source after nap");
    chk(ref_sel, 1'b0, "reference after nap");
    tmr <= 1'b0;
    repeat (4) @(posedge clk);
    rdchk(clock_power_pkg::ADDR_CLOCK_STATUS, 32'h0b);
  endtask : t_switch

  task automatic t_lock();
    logic [31:0] ce;
    logic [31:0] ci;
    pow_set(8'h00);
    lock <= 1'b0;
    repeat (3) @(posedge clk);
    count(20, ce, ci);
    chk(ce, 32'h0, "core enable while unlocked");
    chk(ci, 32'h0, "irq while unlocked");
    lock <= 1'b1;
    count(10, ce, ci);
    chk(ci, 32'h1, "irq on relock");
    count(20, ce, ci);
    chk(ce, 32'd20, "core enable after relock");
  endtask : t_lock

  // ----------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------
  initial begin
    err_count = 0;
    n_tests = 0;
    rst_n = 1'b0;
    hsel = 1'b0;
    haddr = 32'h0;
    htrans = 2'b00;
    hwrite = 1'b0;
    hwdata = 32'h0;
    lock = 1'b1;
    irq = 4'h0;
    tmr = 1'b0;
    repeat (10) @(posedge clk);
    rst_n <= 1'b1;
    @(posedge clk);
    t_reset();
    t_keys();
    t_divide();
    t_modes();
    t_switch();
    t_lock();
    test_done();
  end
endmodule : tb_key_protected_power_clock_control

`default_nettype wire
